//--- rtl/incr_pkg.sv
// Package with the constants, register map and encodings of the incremental position input.
package incr_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_LINES    = 8'h04;
    localparam logic [7:0] OFF_INCR     = 8'h08;
    localparam logic [7:0] OFF_POS      = 8'h0C;
    localparam logic [7:0] OFF_REVS     = 8'h10;
    localparam logic [7:0] OFF_GEAR_NUM = 8'h14;
    localparam logic [7:0] OFF_GEAR_DEN = 8'h18;
    localparam logic [7:0] OFF_SETP_IN  = 8'h1C;
    localparam logic [7:0] OFF_SETP_OUT = 8'h20;
    localparam logic [7:0] OFF_STATUS   = 8'h24;
    localparam logic [7:0] OFF_MASK     = 8'h28;
    localparam logic [7:0] OFF_ERRCODE  = 8'h2C;

    // Control field positions.
    localparam int CTL_MODE_LSB    = 0;
    localparam int CTL_OUTPUT_DIR  = 2;
    localparam int CTL_IGN_COUNT   = 3;
    localparam int CTL_IGN_INDEX   = 4;
    localparam int CTL_FAULT_EN    = 5;
    localparam int CTL_FAULT_HIGH  = 6;
    localparam int CTL_INDEX_USED  = 7;

    // Status bit positions.
    localparam int ST_REV          = 0;
    localparam int ST_INDEX_SLIP   = 1;
    localparam int ST_FAULT        = 2;
    localparam int ST_W            = 3;

    // Reset values.
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_LINES = 32'h0000_0400;
    localparam logic [15:0] RST_GEAR  = 16'h0001;

    // Angle encoder error code 08-7, packed as major and minor bytes.
    localparam logic [15:0] ERR_ENCODER = 16'h0807;

    // Input decoding modes.
    typedef enum logic [1:0] {
        MODE_QUAD    = 2'h0,
        MODE_PULSDIR = 2'h1,
        MODE_UPDOWN  = 2'h2
    } mode_t;

    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;

endpackage : incr_pkg

//--- rtl/track_decoder.sv
// Track synchroniser and step decoder for the three input modes.
`timescale 1ns/100ps
module track_decoder (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Raw pins.
    input  wire logic       track_a,
    input  wire logic       track_b,
    input  wire logic       track_n,
    // Configuration.
    input  wire logic [1:0] mode,
    // Decoded results.
    output logic            step,
    output logic            dir_up,
    output logic            index_rise,
    output logic            n_level
);
    logic [2:0] s1_r, s1_nxt;
    logic [2:0] s2_r, s2_nxt;
    logic [2:0] d_r,  d_nxt;
    logic       a, b, pa, pb, ea, eb;

    // Three flops per pin, two synchroniser stages and a delay; only the second stage and its delayed copy are looked at.
    always_comb begin
        s1_nxt = {track_n, track_b, track_a};
        s2_nxt = s1_r;
        d_nxt  = s2_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= 3'h0;
            s2_r <= 3'h0;
            d_r  <= 3'h0;
        end else if (ce) begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            d_r  <= d_nxt;
        end
    end

    // In quadrature mode an edge of exactly one line is a quarter step, giving fourfold counting.
    always_comb begin
        a  = s2_r[0];
        b  = s2_r[1];
        pa = d_r[0];
        pb = d_r[1];
        ea = a ^ pa;
        eb = b ^ pb;
        index_rise = s2_r[2] & ~d_r[2];
        n_level    = s2_r[2];
        case (mode)
            incr_pkg::MODE_QUAD: begin
                // A lead gives A edge to value unequal B
                step   = ea ^ eb;
                dir_up = ea ? (a != b) : (a == b);
            end
            incr_pkg::MODE_PULSDIR: begin
                step   = ea;
                dir_up = b;
            end
            incr_pkg::MODE_UPDOWN: begin
                // Both lines moving at once violates the source's idle duty; ignored.
                step   = ea ^ eb;
                dir_up = ea;
            end
            default: begin
                step   = 1'b0;
                dir_up = 1'b0;
            end
        endcase
    end
endmodule : track_decoder

//--- rtl/incremental_position_input.sv
// Incremental position input with APB registers, gear scaling and interrupt.
`timescale 1ns/100ps
module incremental_position_input #(
    parameter int POS_W = 32
) (
    // Clock, reset and clock enable.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Connector pins of the incremental port connector.
    input  wire logic        track_a,
    input  wire logic        track_b,
    input  wire logic        track_n,
    // Block outputs.
    output logic             irq,
    output logic             encoder_error,
    output logic             output_mode
);
    logic [31:0]       ctrl_r, ctrl_nxt;
    logic [31:0]       lines_r, lines_nxt;
    logic [POS_W-1:0]  pos_r, pos_nxt;
    logic [31:0]       rev_pos_r, rev_pos_nxt;
    logic [31:0]       revs_r, revs_nxt;
    logic [15:0]       gnum_r, gnum_nxt;
    logic [15:0]       gden_r, gden_nxt;
    logic [31:0]       setp_in_r, setp_in_nxt;
    logic [31:0]       setp_out_r, setp_out_nxt;
    logic [incr_pkg::ST_W-1:0] stat_r, stat_nxt;
    logic [incr_pkg::ST_W-1:0] mask_r, mask_nxt;
    logic [31:0]       prdata_r, prdata_nxt;
    logic              pready_r, pready_nxt;
    logic              pslverr_r, pslverr_nxt;
    logic              irq_r, irq_nxt;
    logic              err_r, err_nxt;
    logic              outm_r, outm_nxt;
    incr_pkg::bus_state_t bus_r, bus_nxt;

    logic              step, dir_up, index_rise, n_level;
    logic              count_en, index_en, fault_act;
    logic [31:0]       incr_per_rev;
    logic              wr_go, rd_go, mapped;
    logic [incr_pkg::ST_W-1:0] ev;

    // Decoding of the tracks in whichever mode software selected.
    track_decoder u_dec (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .track_a    (track_a),
        .track_b    (track_b),
        .track_n    (track_n),
        .mode       (ctrl_r[incr_pkg::CTL_MODE_LSB +: 2]),
        .step       (step),
        .dir_up     (dir_up),
        .index_rise (index_rise),
        .n_level    (n_level)
    );

    // Register index is the byte offset; used by both read and write decode.
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'h0) && (a <= incr_pkg::OFF_ERRCODE);
    endfunction : is_mapped

    // Gear scaling; the quotient is truncated to the setpoint width on purpose.
    function automatic logic [31:0] gear_scale(input logic [31:0] v,
                                               input logic [15:0] n,
                                               input logic [15:0] d);
        logic signed [47:0] prod;
        logic signed [47:0] quo;
        prod = $signed(v) * $signed({1'b0, n});
        quo  = prod;
        if (d != 16'h0)
            quo = prod / $signed({1'b0, d});
        gear_scale = quo[31:0];
    endfunction : gear_scale

    // Option decode shared by counting and index logic.
    always_comb begin
        incr_per_rev = {lines_r[29:0], 2'b00};
        // Frequency output mode releases the port from counting.
        count_en = ~ctrl_r[incr_pkg::CTL_IGN_COUNT] & ~ctrl_r[incr_pkg::CTL_OUTPUT_DIR];
        index_en = ctrl_r[incr_pkg::CTL_INDEX_USED] & ~ctrl_r[incr_pkg::CTL_IGN_INDEX]
                   & (ctrl_r[incr_pkg::CTL_MODE_LSB +: 2] == incr_pkg::MODE_QUAD);
        // The fault shares the index pin, so it only counts without an index track.
        fault_act = ctrl_r[incr_pkg::CTL_FAULT_EN] & ~ctrl_r[incr_pkg::CTL_INDEX_USED]
                    & (n_level == ctrl_r[incr_pkg::CTL_FAULT_HIGH]);
        wr_go  = psel & penable & pwrite & (bus_r == incr_pkg::BUS_ACCESS);
        rd_go  = psel & penable & ~pwrite & (bus_r == incr_pkg::BUS_ACCESS);
        mapped = is_mapped(paddr);
    end

    // Position, revolution tracking and events.
    always_comb begin
        pos_nxt     = pos_r;
        rev_pos_nxt = rev_pos_r;
        revs_nxt    = revs_r;
        ev          = '0;
        if (count_en && step) begin
            pos_nxt = dir_up ? pos_r + 1'b1 : pos_r - 1'b1;
            if (dir_up) begin
                rev_pos_nxt = (rev_pos_r + 32'h1 >= incr_per_rev) ? 32'h0 : rev_pos_r + 32'h1;
            end else begin
                rev_pos_nxt = (rev_pos_r == 32'h0) ? incr_per_rev - 32'h1 : rev_pos_r - 32'h1;
            end
        end
        if (count_en && index_en && index_rise) begin
            // Index resynchronises the revolution so lost increments do not accumulate.
            ev[incr_pkg::ST_REV] = 1'b1;
            revs_nxt    = revs_r + 32'h1;
            // Source must give exactly the configured lines per index.
            if (rev_pos_r != 32'h0)
                ev[incr_pkg::ST_INDEX_SLIP] = 1'b1;
            rev_pos_nxt = 32'h0;
        end
        ev[incr_pkg::ST_FAULT] = fault_act;
    end

    // Register writes, status and the bus answer; set wins over read-clear.
    always_comb begin
        ctrl_nxt     = ctrl_r;
        lines_nxt    = lines_r;
        gnum_nxt     = gnum_r;
        gden_nxt     = gden_r;
        setp_in_nxt  = setp_in_r;
        mask_nxt     = mask_r;
        stat_nxt     = stat_r;
        prdata_nxt   = prdata_r;
        pready_nxt   = 1'b0;
        pslverr_nxt  = 1'b0;
        bus_nxt      = bus_r;
        case (bus_r)
            incr_pkg::BUS_IDLE: begin
                if (psel && !penable)
                    bus_nxt = incr_pkg::BUS_ACCESS;
            end
            incr_pkg::BUS_ACCESS: begin
                if (pready_r) begin
                    bus_nxt = incr_pkg::BUS_IDLE;
                end else begin
                    pready_nxt  = 1'b1;
                    pslverr_nxt = ~mapped;
                end
            end
            default: bus_nxt = incr_pkg::BUS_IDLE;
        endcase
        if (wr_go && pready_r && mapped) begin
            case (paddr)
                incr_pkg::OFF_CTRL:     ctrl_nxt    = pwdata;
                incr_pkg::OFF_LINES:    lines_nxt   = pwdata;
                incr_pkg::OFF_GEAR_NUM: gnum_nxt    = pwdata[15:0];
                incr_pkg::OFF_GEAR_DEN: gden_nxt    = pwdata[15:0];
                incr_pkg::OFF_SETP_IN:  setp_in_nxt = pwdata;
                incr_pkg::OFF_MASK:     mask_nxt    = pwdata[incr_pkg::ST_W-1:0];
                default:                ;
            endcase
        end
        if (rd_go && !pready_r) begin
            case (paddr)
                incr_pkg::OFF_CTRL:     prdata_nxt = ctrl_r;
                incr_pkg::OFF_LINES:    prdata_nxt = lines_r;
                incr_pkg::OFF_INCR:     prdata_nxt = incr_per_rev;
                incr_pkg::OFF_POS:      prdata_nxt = 32'(pos_r);
                incr_pkg::OFF_REVS:     prdata_nxt = revs_r;
                incr_pkg::OFF_GEAR_NUM: prdata_nxt = {16'h0, gnum_r};
                incr_pkg::OFF_GEAR_DEN: prdata_nxt = {16'h0, gden_r};
                incr_pkg::OFF_SETP_IN:  prdata_nxt = setp_in_r;
                incr_pkg::OFF_SETP_OUT: prdata_nxt = setp_out_r;
                incr_pkg::OFF_STATUS:   prdata_nxt = 32'(stat_r);
                incr_pkg::OFF_MASK:     prdata_nxt = 32'(mask_r);
                incr_pkg::OFF_ERRCODE:  prdata_nxt = err_r ? {16'h0, incr_pkg::ERR_ENCODER}
                                                           : 32'h0;
                default:                prdata_nxt = 32'h0;
            endcase
        end
        // Clear only the bits the reader saw, so an event caught after the snapshot survives.
        if (rd_go && pready_r && paddr == incr_pkg::OFF_STATUS)
            stat_nxt = stat_r & ~prdata_r[incr_pkg::ST_W-1:0];
        stat_nxt     = stat_nxt | ev;
        setp_out_nxt = gear_scale(setp_in_r, gnum_r, gden_r);
        irq_nxt      = |(stat_nxt & mask_nxt);
        err_nxt      = stat_nxt[incr_pkg::ST_FAULT];
        outm_nxt     = ctrl_r[incr_pkg::CTL_OUTPUT_DIR];
    end

    // State registers; ce low freezes everything.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= incr_pkg::RST_CTRL;
            lines_r    <= incr_pkg::RST_LINES;
            pos_r      <= '0;
            rev_pos_r  <= 32'h0;
            revs_r     <= 32'h0;
            gnum_r     <= incr_pkg::RST_GEAR;
            gden_r     <= incr_pkg::RST_GEAR;
            setp_in_r  <= 32'h0;
            setp_out_r <= 32'h0;
            stat_r     <= '0;
            mask_r     <= '0;
            prdata_r   <= 32'h0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            irq_r      <= 1'b0;
            err_r      <= 1'b0;
            outm_r     <= 1'b0;
            bus_r      <= incr_pkg::BUS_IDLE;
        end else if (ce) begin
            ctrl_r     <= ctrl_nxt;
            lines_r    <= lines_nxt;
            pos_r      <= pos_nxt;
            rev_pos_r  <= rev_pos_nxt;
            revs_r     <= revs_nxt;
            gnum_r     <= gnum_nxt;
            gden_r     <= gden_nxt;
            setp_in_r  <= setp_in_nxt;
            setp_out_r <= setp_out_nxt;
            stat_r     <= stat_nxt;
            mask_r     <= mask_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            irq_r      <= irq_nxt;
            err_r      <= err_nxt;
            outm_r     <= outm_nxt;
            bus_r      <= bus_nxt;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign irq         = irq_r;
    assign encoder_error = err_r;
    assign output_mode = outm_r;

    // Ignore-count holds the position across any track activity.
    property p_ign_count;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl_r[incr_pkg::CTL_IGN_COUNT]) |=> $stable(pos_r);
    endproperty
    a_ign_count: assert property (p_ign_count) else $error("position moved while ignored");

    // A counted up step raises the position by exactly one.
    property p_step_up;
        @(posedge pclk) disable iff (!presetn)
        (ce && count_en && step && dir_up && !(index_en && index_rise)) |=> pos_r == $past(pos_r) + 1'b1;
    endproperty
    a_step_up: assert property (p_step_up) else $error("up step not counted");

    // Increments per rotation is four times the line count.
    property p_incr;
        @(posedge pclk) disable iff (!presetn)
        incr_per_rev == 32'(lines_r * 4);
    endproperty
    a_incr: assert property (p_incr) else $error("increments not fourfold");

    // Index with ignore-index never bumps the revolution count.
    property p_ign_index;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl_r[incr_pkg::CTL_IGN_INDEX]) |=> revs_r == $past(revs_r);
    endproperty
    a_ign_index: assert property (p_ign_index) else $error("index counted while ignored");

    // An active fault shows on the error output at the next edge.
    sequence s_fault; ce && fault_act; endsequence
    sequence s_fault_seen; encoder_error; endsequence
    property p_fault;
        @(posedge pclk) disable iff (!presetn)
        s_fault |=> s_fault_seen;
    endproperty
    a_fault: assert property (p_fault) else $error("fault not reported");

    // A configured index track never raises the fault bit.
    property p_fault_idx;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl_r[incr_pkg::CTL_INDEX_USED] && !stat_r[incr_pkg::ST_FAULT])
            |=> !stat_r[incr_pkg::ST_FAULT];
    endproperty
    a_fault_idx: assert property (p_fault_idx) else $error("fault with index track");

    // Unity gear passes the setpoint unchanged.
    property p_gear;
        @(posedge pclk) disable iff (!presetn)
        (ce && gnum_r == 16'h1 && gden_r == 16'h1) |=> setp_out_r == $past(setp_in_r);
    endproperty
    a_gear: assert property (p_gear) else $error("unity gear altered setpoint");

    // Output mode follows the control bit.
    property p_outm;
        @(posedge pclk) disable iff (!presetn)
        ce |=> output_mode == $past(ctrl_r[incr_pkg::CTL_OUTPUT_DIR]);
    endproperty
    a_outm: assert property (p_outm) else $error("output mode mismatch");

    // A counted down step lowers the position by one.
    property p_step_down;
        @(posedge pclk) disable iff (!presetn)
        (ce && count_en && step && !dir_up) |=> pos_r == $past(pos_r) - 1'b1;
    endproperty
    a_step_down: assert property (p_step_down) else $error("down step lost");

    // An evaluated index adds one revolution.
    property p_index_rev;
        @(posedge pclk) disable iff (!presetn)
        (ce && count_en && index_en && index_rise) |=> revs_r == $past(revs_r) + 32'h1;
    endproperty
    a_index_rev: assert property (p_index_rev) else $error("index not counted");

    // An evaluated index realigns the revolution position.
    property p_index_zero;
        @(posedge pclk) disable iff (!presetn)
        (ce && count_en && index_en && index_rise) |=> rev_pos_r == 32'h0;
    endproperty
    a_index_zero: assert property (p_index_zero) else $error("no realign");

    // Ignored counts also hold the revolutions.
    property p_ign_rev;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl_r[incr_pkg::CTL_IGN_COUNT]) |=> $stable(revs_r);
    endproperty
    a_ign_rev: assert property (p_ign_rev) else $error("revs moved while ignored");

    // An ignored index raises no revolution event.
    property p_ign_stat;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl_r[incr_pkg::CTL_IGN_INDEX] && !stat_r[incr_pkg::ST_REV])
            |=> !stat_r[incr_pkg::ST_REV];
    endproperty
    a_ign_stat: assert property (p_ign_stat) else $error("ignored index flagged");

    // A disabled fault input never sets the fault bit.
    property p_fault_off;
        @(posedge pclk) disable iff (!presetn)
        (ce && !ctrl_r[incr_pkg::CTL_FAULT_EN] && !stat_r[incr_pkg::ST_FAULT])
            |=> !stat_r[incr_pkg::ST_FAULT];
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("disabled fault set");

    // Frequency output mode leaves the position alone.
    property p_outm_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && ctrl_r[incr_pkg::CTL_OUTPUT_DIR]) |=> $stable(pos_r);
    endproperty
    a_outm_hold: assert property (p_outm_hold) else $error("output mode counted");
endmodule : incremental_position_input

//--- dv/encoder_model.sv
// Behavioural incremental encoder that drives the three track pins.
`timescale 1ns/100ps
module encoder_model (
    // Clock.
    input  wire logic pclk,
    // Track pins.
    output logic      track_a,
    output logic      track_b,
    output logic      track_n
);
    logic [1:0] phase;

    // A real encoder always drives its lines, so they start at defined levels.
    initial begin
        phase   = 2'h0;
        track_a = 1'b0;
        track_b = 1'b0;
        track_n = 1'b0;
    end

    // Each level is held long enough for the two synchroniser flops and the edge compare.
    task automatic settle();
        repeat (5) @(posedge pclk);
    endtask : settle

    // One quadrature edge; the first track leads when moving up.
    task automatic quad_step(input logic up);
        @(posedge pclk);
        phase = up ? phase + 2'h1 : phase - 2'h1;
        track_a <= (phase == 2'h1) || (phase == 2'h2);
        track_b <= phase[1];
        settle();
    endtask : quad_step

    // Direction is set before the step edge so it is stable when the edge is counted.
    task automatic pd_step(input logic up);
        @(posedge pclk);
        track_b <= up;
        settle();
        @(posedge pclk);
        track_a <= ~track_a;
        settle();
    endtask : pd_step

    // Only the line of the chosen direction moves; the other rests.
    task automatic ud_step(input logic up);
        @(posedge pclk);
        if (up) begin
            track_a <= ~track_a;
        end else begin
            track_b <= ~track_b;
        end
        settle();
    endtask : ud_step

    // Level on the index pin, also used as the fault input.
    task automatic set_n(input logic v);
        @(posedge pclk);
        track_n <= v;
        settle();
    endtask : set_n

    // One index pulse, given after a whole number of lines by the caller.
    task automatic index_pulse();
        set_n(1'b1);
        set_n(1'b0);
    endtask : index_pulse
endmodule : encoder_model

//--- dv/incremental_position_input_tb.sv
// Self-checking testbench of the incremental position input.
`timescale 1ns/100ps
module incremental_position_input_tb;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, base;
    logic        pready, pslverr, track_a, track_b, track_n, irq, encoder_error, output_mode;
    logic        ce;
    int          error_cnt;
    int          num_checks;

    incremental_position_input dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .track_a(track_a), .track_b(track_b), .track_n(track_n),
        .irq(irq), .encoder_error(encoder_error), .output_mode(output_mode));

    encoder_model enc (.pclk(pclk), .track_a(track_a), .track_b(track_b), .track_n(track_n));

    // Clock at 50 MHz.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready.
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(name, exp, d);
    endtask : rdchk

    task automatic tend(input string name);
        $display("test %s done", name);
    endtask : tend

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // A hang is cut short well after the tests should have ended.
    initial begin
        repeat (30000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    // Main sequence.
    initial begin
        logic [31:0] d;
        logic        e;
        error_cnt = 0;
        num_checks = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("ctrl", incr_pkg::OFF_CTRL, 32'h0000_0000);
        rdchk("lines", incr_pkg::OFF_LINES, 32'h0000_0400);
        rdchk("incr", incr_pkg::OFF_INCR, 32'h0000_1000);
        rdchk("gear_num", incr_pkg::OFF_GEAR_NUM, 32'h0000_0001);
        rdchk("gear_den", incr_pkg::OFF_GEAR_DEN, 32'h0000_0001);
        apb(1'b0, 8'h30, 32'h0, d, e);
        chk("unmapped err", 32'h0000_0001, {31'h0, e});
        apb(1'b1, 8'h06, 32'h0, d, e);
        chk("misaligned err", 32'h0000_0001, {31'h0, e});
        tend("reset");
        rd(incr_pkg::OFF_POS, base);
        repeat (8) enc.quad_step(1'b1);
        rdchk("quad up", incr_pkg::OFF_POS, base + 32'h0000_0008);
        repeat (3) enc.quad_step(1'b0);
        rdchk("quad down", incr_pkg::OFF_POS, base + 32'h0000_0005);
        tend("quadrature");
        wr(incr_pkg::OFF_CTRL, 32'h0000_0001);
        rd(incr_pkg::OFF_POS, base);
        repeat (4) enc.pd_step(1'b1);
        repeat (2) enc.pd_step(1'b0);
        rdchk("pulse dir", incr_pkg::OFF_POS, base + 32'h0000_0002);
        wr(incr_pkg::OFF_CTRL, 32'h0000_0002);
        rd(incr_pkg::OFF_POS, base);
        repeat (3) enc.ud_step(1'b1);
        enc.ud_step(1'b0);
        rdchk("up down", incr_pkg::OFF_POS, base + 32'h0000_0002);
        tend("modes");
        wr(incr_pkg::OFF_CTRL, 32'h0000_0008);
        rd(incr_pkg::OFF_POS, base);
        repeat (3) enc.quad_step(1'b1);
        rdchk("ignore count", incr_pkg::OFF_POS, base);
        wr(incr_pkg::OFF_CTRL, 32'h0000_0004);
        repeat (3) enc.quad_step(1'b1);
        chk("output mode", 32'h0000_0001, {31'h0, output_mode});
        rdchk("output pos", incr_pkg::OFF_POS, base);
        tend("ignore");
        wr(incr_pkg::OFF_LINES, 32'h0000_0002);
        rdchk("incr", incr_pkg::OFF_INCR, 32'h0000_0008);
        wr(incr_pkg::OFF_CTRL, 32'h0000_0080);
        wr(incr_pkg::OFF_MASK, 32'h0000_0001);
        rd(incr_pkg::OFF_STATUS, d);
        rd(incr_pkg::OFF_REVS, base);
        repeat (8) enc.quad_step(1'b1);
        enc.index_pulse();
        rdchk("revs", incr_pkg::OFF_REVS, base + 32'h0000_0001);
        chk("irq set", 32'h0000_0001, {31'h0, irq});
        rd(incr_pkg::OFF_STATUS, d);
        chk("index seen", 32'h0000_0001, d & 32'h0000_0001);
        repeat (2) @(posedge pclk);
        chk("irq clear", 32'h0000_0000, {31'h0, irq});
        wr(incr_pkg::OFF_MASK, 32'h0000_0000);
        enc.index_pulse();
        chk("irq masked", 32'h0000_0000, {31'h0, irq});
        wr(incr_pkg::OFF_CTRL, 32'h0000_0090);
        rd(incr_pkg::OFF_STATUS, d);
        rd(incr_pkg::OFF_REVS, base);
        enc.index_pulse();
        rdchk("revs ignored", incr_pkg::OFF_REVS, base);
        tend("index");
        wr(incr_pkg::OFF_CTRL, 32'h0000_0020);
        repeat (4) @(posedge pclk);
        chk("fault low", 32'h0000_0001, {31'h0, encoder_error});
        rdchk("errcode", incr_pkg::OFF_ERRCODE, 32'h0000_0807);
        enc.set_n(1'b1);
        rd(incr_pkg::OFF_STATUS, d);
        repeat (2) @(posedge pclk);
        chk("fault gone", 32'h0000_0000, {31'h0, encoder_error});
        ce <= 1'b0;
        enc.set_n(1'b0);
        chk("ce frozen", 32'h0000_0000, {31'h0, encoder_error});
        ce <= 1'b1;
        repeat (6) @(posedge pclk);
        chk("ce resumed", 32'h0000_0001, {31'h0, encoder_error});
        enc.set_n(1'b1);
        wr(incr_pkg::OFF_CTRL, 32'h0000_0060);
        repeat (4) @(posedge pclk);
        chk("fault high", 32'h0000_0001, {31'h0, encoder_error});
        wr(incr_pkg::OFF_CTRL, 32'h0000_00E0);
        rd(incr_pkg::OFF_STATUS, d);
        repeat (2) @(posedge pclk);
        chk("fault with index", 32'h0000_0000, {31'h0, encoder_error});
        wr(incr_pkg::OFF_CTRL, 32'h0000_0040);
        rd(incr_pkg::OFF_STATUS, d);
        repeat (2) @(posedge pclk);
        chk("fault disabled", 32'h0000_0000, {31'h0, encoder_error});
        tend("fault");
        wr(incr_pkg::OFF_SETP_IN, 32'h0000_0064);
        rdchk("setp unity", incr_pkg::OFF_SETP_OUT, 32'h0000_0064);
        wr(incr_pkg::OFF_GEAR_NUM, 32'h0000_0003);
        wr(incr_pkg::OFF_GEAR_DEN, 32'h0000_0002);
        rdchk("setp geared", incr_pkg::OFF_SETP_OUT, 32'h0000_0096);
        tend("gear");
        summarize();
    end
endmodule : incremental_position_input_tb
